// file: pkg/sw_clk_fault_defs.vh
// Constants for the switching clock and fault control block
`ifndef SW_CLK_FAULT_DEFS_VH
`define SW_CLK_FAULT_DEFS_VH

// ============================================================
// Register byte addresses
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_MASK 4'h8
`define ADDR_STATE 4'hc

// ============================================================
// Control register fields
`define CTRL_WARN_EN 0
`define CTRL_SAFE_TIMEOUT_DISABLE 1
`define CTRL_UV_RST_EN 2
`define CTRL_PWD_LSB 4
`define CTRL_PWD_MSB 7
`define CTRL_RESET 8'h82

// ============================================================
// Status register bits (sticky, write one to clear)
`define ST_CLK_WARN 0
`define ST_PRIMARY_BUCK_CLK 1
`define ST_SYNC_LOSS 2
`define ST_INTERNAL_SYSTEM_CLOCK 3
`define ST_GATE_UV 4
`define ST_GATE_OV 5
`define ST_COUNT 6

// ============================================================
// Device states as reported
`define DEV_OFF 3'h0
`define DEV_RESET 3'h1
`define DEV_ACTIVE 3'h2
`define DEV_SAFE 3'h3

// ============================================================
// Sync activity detection: edges needed within a window
`define SYNC_EDGES 3'h4
`define SYNC_WIN_NS 20000
`define SYNC_WIN_CYC (`SYNC_WIN_NS / 100)
`define SYNC_CNT_W 8

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/sync_activity_detect.v
// Detects activity on the external sync clock and its falling edges
`timescale 1ns/1ns
`include "sw_clk_fault_defs.vh"

module sync_activity_detect (
  input wire clk,
  input wire rst_n,
  input wire sync_in,
  output reg active,
  output reg fall
);

  reg sync_a;
  reg sync_b;
  reg sync_c;
  reg [2:0] edges;
  reg [`SYNC_CNT_W-1:0] win;

  // ==========================================================
  // Two-flop synchroniser, then edge detection on later stages
  always @(posedge clk) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= sync_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Count edges in a fixed window; too few means the clock is lost
  always @(posedge clk) begin
    if (!rst_n) begin
      edges <= 3'h0;
      win <= {`SYNC_CNT_W{1'b0}};
      active <= 1'b0;
      fall <= 1'b0;
    end else begin
      fall <= sync_c & ~sync_b;
      if (win == `SYNC_WIN_CYC - 1) begin
        win <= {`SYNC_CNT_W{1'b0}};
        active <= (edges >= `SYNC_EDGES);
        edges <= 3'h0;
      end else begin
        win <= win + 1'b1;
        if ((sync_c ^ sync_b) && edges != 3'h7)
          edges <= edges + 1'b1;
      end
    end
  end

endmodule // sync_activity_detect

// file: rtl/sw_clk_fault_ctrl.v
// Switching clock selection and clock/gate-supply fault control
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "sw_clk_fault_defs.vh"

// Behaviour
// - Gate supply undervoltage: regulators off, OFF, latch
// - Gate supply overvoltage: regulators off, OFF, latch
// - Gate supply from analog input above threshold
// - Sync activity at power-up selects external clock
// - Switching cycle starts on sync falling edge
// - Sync loss falls back to oscillator
// - Warning with enable: flag, SAFE, count, interrupt
// - Warning without enable: flag, status bit 0
// - Primary buck clock error disables all regulators
// - Primary buck clock error: SAFE, count, interrupt
// - Outputs below undervoltage move SAFE to RESET
// - RESET restarts only with good clocks or discharged
// - Restart primary, then secondary, then boost
// - System clock fault only flags, no reaction
// - Error counter at threshold forces OFF
module sw_clk_fault_ctrl (
  input wire REF_CLK,
  input wire RST_N,
  input wire [3:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [3:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire SYNC_IN,
  input wire CLK_WARN,
  input wire PRIMARY_BUCK_CLK_FAULT,
  input wire SYSTEM_CLOCK_FAULT,
  input wire OSC_GOOD,
  input wire CLOCKS_GOOD,
  input wire GATE_UV,
  input wire GATE_OV,
  input wire EXT_SUPPLY_ABOVE,
  input wire OUTPUTS_UV,
  input wire OUTPUTS_DISCHARGED,
  input wire PRIMARY_ABOVE_UV,
  output reg PRIMARY_BUCK_EN,
  output reg SECONDARY_BUCK_EN,
  output reg BOOST_EN,
  output reg USE_EXT_CLOCK,
  output reg CYCLE_START,
  output reg GATE_FROM_EXT,
  output reg FAULT_INTERRUPT_PIN_N,
  output reg IRQ,
  output reg [2:0] DEVICE_STATE
);

  // One-hot device state machine
  localparam [3:0] S_OFF = 4'b0001;
  localparam [3:0] S_RESET = 4'b0010;
  localparam [3:0] S_ACTIVE = 4'b0100;
  localparam [3:0] S_SAFE = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [7:0] ctrl;
  reg [`ST_COUNT-1:0] status;
  reg [`ST_COUNT-1:0] mask;
  reg [3:0] err_cnt;
  reg [1:0] restart_step;
  reg power_up_done;
  reg [`ST_COUNT-1:0] in_a;
  reg [`ST_COUNT-1:0] in_b;
  reg [`ST_COUNT-1:0] in_prev;
  reg [4:0] lvl_a;
  reg [4:0] lvl_b;
  reg ext_a;
  reg ext_b;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire ext_active;
  wire ext_fall;
  wire [`ST_COUNT-1:0] rise;
  wire [`ST_COUNT-1:0] w1c;
  wire wr_fire;
  wire safe_entry;
  wire off_entry;

  // Decode of register index, used by both write and read paths
  function [1:0] reg_sel;
    input [3:0] addr;
    begin
      reg_sel = addr[3:2];
    end
  endfunction

  sync_activity_detect u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .sync_in(SYNC_IN),
    .active(ext_active),
    .fall(ext_fall)
  );

  // ==========================================================
  // Input synchronisers: event pins and level pins
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      in_a <= {`ST_COUNT{1'b0}};
      in_b <= {`ST_COUNT{1'b0}};
      in_prev <= {`ST_COUNT{1'b0}};
      lvl_a <= 5'h00;
      lvl_b <= 5'h00;
      ext_a <= 1'b0;
      ext_b <= 1'b0;
    end else begin
      ext_a <= EXT_SUPPLY_ABOVE;
      ext_b <= ext_a;
      in_a <= {GATE_OV, GATE_UV, SYSTEM_CLOCK_FAULT, 1'b0, PRIMARY_BUCK_CLK_FAULT, CLK_WARN};
      in_b <= in_a;
      in_prev <= in_b;
      lvl_a <= {PRIMARY_ABOVE_UV, OUTPUTS_DISCHARGED, OUTPUTS_UV, CLOCKS_GOOD, OSC_GOOD};
      lvl_b <= lvl_a;
    end
  end

  // Fault events fire on the rising edge of each synchronised level
  assign rise = in_b & ~in_prev;
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
  assign w1c = (wr_fire && reg_sel(aw_addr) == reg_sel(`ADDR_STATUS) && w_strb[0])
               ? w_data[`ST_COUNT-1:0] : {`ST_COUNT{1'b0}};

  // Primary buck clock error counts only while the oscillator is good
  assign safe_entry = (rise[`ST_CLK_WARN] && ctrl[`CTRL_WARN_EN])
                    || (rise[`ST_PRIMARY_BUCK_CLK] && lvl_b[0])
                    || (status[`ST_SYNC_LOSS] == 1'b0 && USE_EXT_CLOCK && !ext_active);
  assign off_entry = rise[`ST_GATE_UV] || rise[`ST_GATE_OV];

  // ==========================================================
  // Device state transitions
  always @* begin
    next_state = state;
    case (state)
      S_OFF: next_state = S_OFF;
      S_RESET: begin
        if (restart_step == 2'h3)
          next_state = S_ACTIVE;
      end
      S_ACTIVE: next_state = S_ACTIVE;
      S_SAFE: begin
        if (lvl_b[2] && ctrl[`CTRL_UV_RST_EN])
          next_state = S_RESET;
      end
      default: next_state = S_OFF;
    endcase
    if (safe_entry && state != S_OFF)
      next_state = S_SAFE;
    // Five-bit sum so a saturated count cannot wrap below the threshold
    if (safe_entry && state != S_OFF
        && ({1'b0, err_cnt} + 5'h01) >= {1'b0, ctrl[`CTRL_PWD_MSB:`CTRL_PWD_LSB]})
      next_state = S_OFF;
    if (off_entry)
      next_state = S_OFF;
  end

  // ==========================================================
  // State, error counter and restart sequencing
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      state <= S_RESET;
      err_cnt <= 4'h0;
      restart_step <= 2'h0;
      PRIMARY_BUCK_EN <= 1'b0;
      SECONDARY_BUCK_EN <= 1'b0;
      BOOST_EN <= 1'b0;
      DEVICE_STATE <= `DEV_RESET;
    end else begin
      state <= next_state;
      if (safe_entry && state != S_OFF && err_cnt != 4'hf)
        err_cnt <= err_cnt + 1'b1;
      case (next_state)
        S_OFF: DEVICE_STATE <= `DEV_OFF;
        S_RESET: DEVICE_STATE <= `DEV_RESET;
        S_ACTIVE: DEVICE_STATE <= `DEV_ACTIVE;
        default: DEVICE_STATE <= `DEV_SAFE;
      endcase
      if (off_entry || (rise[`ST_PRIMARY_BUCK_CLK] && lvl_b[0])) begin
        PRIMARY_BUCK_EN <= 1'b0;
        SECONDARY_BUCK_EN <= 1'b0;
        BOOST_EN <= 1'b0;
        restart_step <= 2'h0;
      end else if (next_state == S_OFF) begin
        PRIMARY_BUCK_EN <= 1'b0;
        SECONDARY_BUCK_EN <= 1'b0;
        BOOST_EN <= 1'b0;
      end else if (next_state == S_RESET && state != S_RESET) begin
        // Entering RESET drops every rail so the restart begins at the primary
        PRIMARY_BUCK_EN <= 1'b0;
        SECONDARY_BUCK_EN <= 1'b0;
        BOOST_EN <= 1'b0;
        restart_step <= 2'h0;
      end else if (state == S_RESET) begin
        // Primary first, then secondary and boost once primary is up
        case (restart_step)
          2'h0: begin
            if ((lvl_b[0] && lvl_b[1]) || lvl_b[3]) begin
              PRIMARY_BUCK_EN <= 1'b1;
              restart_step <= 2'h1;
            end
          end
          2'h1: begin
            if (lvl_b[4]) begin
              SECONDARY_BUCK_EN <= 1'b1;
              restart_step <= 2'h2;
            end
          end
          2'h2: begin
            BOOST_EN <= 1'b1;
            restart_step <= 2'h3;
          end
          default: restart_step <= 2'h0;
        endcase
      end else begin
        restart_step <= 2'h0;
      end
    end
  end

  // ==========================================================
  // Clock source: pick at power-up, fall back on loss
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      power_up_done <= 1'b0;
      USE_EXT_CLOCK <= 1'b0;
      CYCLE_START <= 1'b0;
      GATE_FROM_EXT <= 1'b0;
    end else begin
      // Decision waits for the first full detection window
      if (!power_up_done && ext_active) begin
        USE_EXT_CLOCK <= 1'b1;
        power_up_done <= 1'b1;
      end else if (USE_EXT_CLOCK && !ext_active) begin
        USE_EXT_CLOCK <= 1'b0;
      end
      CYCLE_START <= USE_EXT_CLOCK && ext_fall;
      // Pass switch follows the synchronised supply comparator
      GATE_FROM_EXT <= ext_b;
    end
  end

  // ==========================================================
  // Sticky status flags: set wins over a write-one clear
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      status <= {`ST_COUNT{1'b0}};
    end else begin
      status <= (status & ~w1c) | rise;
      if (USE_EXT_CLOCK && !ext_active)
        status[`ST_SYNC_LOSS] <= 1'b1;
    end
  end

  // Interrupt pin low on SAFE-causing faults; IRQ on any flag whose mask bit is set
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      FAULT_INTERRUPT_PIN_N <= 1'b1;
      IRQ <= 1'b0;
    end else begin
      if (safe_entry)
        FAULT_INTERRUPT_PIN_N <= 1'b0;
      else if (status == {`ST_COUNT{1'b0}})
        FAULT_INTERRUPT_PIN_N <= 1'b1;
      IRQ <= |(status & mask);
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
      ctrl <= `CTRL_RESET;
      mask <= {`ST_COUNT{1'b0}};
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (reg_sel(aw_addr) == reg_sel(`ADDR_STATE)) ? `RESP_SLVERR : `RESP_OKAY;
        if (reg_sel(aw_addr) == reg_sel(`ADDR_CTRL) && w_strb[0])
          ctrl <= w_data[7:0];
        if (reg_sel(aw_addr) == reg_sel(`ADDR_MASK) && w_strb[0])
          mask <= w_data[`ST_COUNT-1:0];
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel, one read at a time
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `RESP_OKAY;
        case (reg_sel(S_AXI_ARADDR))
          2'h0: S_AXI_RDATA <= {24'h000000, ctrl};
          2'h1: S_AXI_RDATA <= {26'h0000000, status};
          2'h2: S_AXI_RDATA <= {26'h0000000, mask};
          default: S_AXI_RDATA <= {20'h00000, err_cnt, 1'b0, USE_EXT_CLOCK, restart_step,
                                   1'b0, DEVICE_STATE};
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

endmodule // sw_clk_fault_ctrl

// file: tb/sw_clk_fault_ctrl_sva.sv
// Assertion checker for the switching clock and fault control block
`timescale 1ns/1ns
`include "sw_clk_fault_defs.vh"

// ============================================================
// Checker on the top-level ports
module sw_clk_fault_ctrl_sva (
  input logic REF_CLK,
  input logic RST_N,
  input logic SYNC_IN,
  input logic PRIMARY_BUCK_CLK_FAULT,
  input logic SYSTEM_CLOCK_FAULT,
  input logic OSC_GOOD,
  input logic GATE_UV,
  input logic GATE_OV,
  input logic EXT_SUPPLY_ABOVE,
  input logic PRIMARY_BUCK_EN,
  input logic SECONDARY_BUCK_EN,
  input logic BOOST_EN,
  input logic USE_EXT_CLOCK,
  input logic CYCLE_START,
  input logic GATE_FROM_EXT,
  input logic FAULT_INTERRUPT_PIN_N,
  input logic [2:0] DEVICE_STATE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic sync_d;
  logic [9:0] quiet;
  wire off3 = !PRIMARY_BUCK_EN && !SECONDARY_BUCK_EN && !BOOST_EN;
  // Idle time of the sync line; saturates so a long stop never wraps
  always @(posedge REF_CLK) begin
    sync_d <= SYNC_IN;
    if (!RST_N || SYNC_IN != sync_d) quiet <= 10'h0;
    else if (quiet != 10'h3ff) quiet <= quiet + 10'h1;
  end
  a_gate_fault_off: assert property (($rose(GATE_UV) || $rose(GATE_OV))
    |-> ##[1:8] (DEVICE_STATE == `DEV_OFF && off3)) else $error("gate fault kept rails");
  a_ext_path: assert property ($stable(EXT_SUPPLY_ABOVE) [*6]
    |-> GATE_FROM_EXT == EXT_SUPPLY_ABOVE) else $error("gate path wrong");
  a_cycle_on_fall: assert property ($fell(SYNC_IN) && USE_EXT_CLOCK
    |-> ##[1:6] CYCLE_START) else $error("no cycle start");
  a_sync_fallback: assert property (quiet == 10'h1c2 |-> !USE_EXT_CLOCK)
    else $error("dead sync still used");
  a_primary_buck_rails_off: assert property ($rose(PRIMARY_BUCK_CLK_FAULT) && OSC_GOOD
    |-> ##[1:8] off3) else $error("rails on after clock error");
  a_primary_buck_safe_pin: assert property ($rose(PRIMARY_BUCK_CLK_FAULT) && OSC_GOOD |-> ##[1:8]
    (DEVICE_STATE == `DEV_SAFE && !FAULT_INTERRUPT_PIN_N || DEVICE_STATE == `DEV_OFF))
    else $error("no safe entry");
  a_safe_exit: assert property (DEVICE_STATE == `DEV_SAFE |=> DEVICE_STATE != `DEV_ACTIVE)
    else $error("safe left to active");
  a_restart_order: assert property ($rose(SECONDARY_BUCK_EN) |-> PRIMARY_BUCK_EN ##1 BOOST_EN)
    else $error("restart order");
  a_internal_system_clock_quiet: assert property ($rose(SYSTEM_CLOCK_FAULT) && !PRIMARY_BUCK_CLK_FAULT
    |=> $stable(DEVICE_STATE) [*8]) else $error("state moved on system clock fault");
  a_off_holds: assert property (DEVICE_STATE == `DEV_OFF |=> DEVICE_STATE == `DEV_OFF && off3)
    else $error("left off");
  c_safe: cover property (DEVICE_STATE == `DEV_SAFE);
  c_boost: cover property ($rose(BOOST_EN));
  c_cycle: cover property (CYCLE_START);
endmodule // sw_clk_fault_ctrl_sva

bind sw_clk_fault_ctrl sw_clk_fault_ctrl_sva chk (.*);

// file: tb/sync_clock_source.sv
// Model of the external sync clock source feeding the block
`timescale 1ns/1ns

// ============================================================
// Source that parks low when stopped; a half period that is a multiple of four keeps its edges off the rising edge
module sync_clock_source #(
  parameter HALF_NS = 372
) (
  input wire run,
  output reg sync_out
);
  initial sync_out = 1'b0;
  // Toggle while running, otherwise hold the idle level
  always begin
    #HALF_NS;
    sync_out = run ? ~sync_out : 1'b0;
  end
endmodule // sync_clock_source

// file: tb/sw_clk_fault_ctrl_tb.sv
// Self-checking bench for the switching clock and fault control block
`timescale 1ns/1ns
`include "sw_clk_fault_defs.vh"

// ============================================================
// Bench top; the bench plays the microcontroller on the register bus
module sw_clk_fault_ctrl_tb;
  localparam [3:0] PWD = 4'h3;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] awaddr = 4'h0, araddr = 4'h0;
  reg [31:0] wdata = 32'h0, rd;
  reg awvalid, wvalid, bready, arvalid, rready, sync_run, osc_good, clocks_good;
  reg ext_above, outputs_uv, outputs_dis, prim_above;
  reg [4:0] flt;
  reg [7:0] rnd = 8'h57;
  wire awready, wready, bvalid, arready, rvalid, sync_line;
  wire p_en, s_en, b_en, use_ext, cyc, gate_ext, pin_n, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] state;
  integer fail_count = 0, n_checks = 0, cyc_cnt = 0, exp_state, exp_cnt, i, n;

  // ============================================================
  // Clock, far-side sync source and the block
  always #50 clk = ~clk;
  sync_clock_source src (.run(sync_run), .sync_out(sync_line));
  sw_clk_fault_ctrl DUT (
    .REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SYNC_IN(sync_line), .CLK_WARN(flt[0]), .PRIMARY_BUCK_CLK_FAULT(flt[1]),
    .SYSTEM_CLOCK_FAULT(flt[2]), .OSC_GOOD(osc_good), .CLOCKS_GOOD(clocks_good),
    .GATE_UV(flt[3]), .GATE_OV(flt[4]), .EXT_SUPPLY_ABOVE(ext_above), .OUTPUTS_UV(outputs_uv),
    .OUTPUTS_DISCHARGED(outputs_dis), .PRIMARY_ABOVE_UV(prim_above), .PRIMARY_BUCK_EN(p_en),
    .SECONDARY_BUCK_EN(s_en), .BOOST_EN(b_en), .USE_EXT_CLOCK(use_ext), .CYCLE_START(cyc),
    .GATE_FROM_EXT(gate_ext), .FAULT_INTERRUPT_PIN_N(pin_n), .IRQ(irq), .DEVICE_STATE(state)
  );

  // ============================================================
  // Helpers
  function [7:0] next_rnd(input [7:0] s);
    next_rnd = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task tick(input integer k);
    repeat (k) @(posedge clk);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Write: each channel is released at the edge it is taken, response checked
  task axw(input [3:0] a, input [31:0] d, input [1:0] er);
    reg ad, wd;
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      while (!(ad && wd)) begin
        @(posedge clk);
        if (!ad && awready) begin
          ad = 1'b1;
          awvalid <= 1'b0;
        end
        if (!wd && wready) begin
          wd = 1'b1;
          wvalid <= 1'b0;
        end
      end
      while (!bvalid) @(posedge clk);
      chk(32'(bresp), 32'(er));
      bready <= 1'b0;
    end
  endtask
  task axr(input [3:0] a, output [31:0] d);
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge clk);
      while (!arready) @(posedge clk);
      arvalid <= 1'b0;
      @(posedge clk);
      while (!rvalid) @(posedge clk);
      d = rdata;
      rready <= 1'b0;
    end
  endtask
  task rchk(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      axr(a, rd);
      chk(rd & m, e);
    end
  endtask
  // Raise one fault line for a random span, then let the event land
  task fire(input integer k);
    begin
      flt[k] <= 1'b1;
      rnd = next_rnd(rnd);
      tick(4 + rnd[2:0]);
      flt[k] <= 1'b0;
      tick(6);
    end
  endtask
  // Reference model: a SAFE-causing event bumps the count, OFF at the threshold
  task model_err;
    begin
      exp_cnt = exp_cnt + 1;
      exp_state = (exp_cnt >= PWD) ? `DEV_OFF : `DEV_SAFE;
    end
  endtask
  task mchk;
    begin
      axr(`ADDR_STATE, rd);
      chk(rd & 32'hf07, (exp_cnt << 8) | exp_state);
      chk(32'(state), exp_state);
    end
  endtask
  task do_reset;
    begin
      rst_n <= 1'b0;
      tick(6);
      rst_n <= 1'b1;
      exp_cnt = 0;
      tick(1);
    end
  endtask
  // Drop the rails, then walk the restart back to ACTIVE
  task recover;
    begin
      prim_above <= 1'b0;
      outputs_uv <= 1'b1;
      tick(8);
      chk(32'({state, p_en, s_en}), 32'h6);
      outputs_uv <= 1'b0;
      prim_above <= 1'b1;
      tick(8);
      chk(32'({p_en, s_en, b_en, state}), 32'h3a);
      exp_state = `DEV_ACTIVE;
    end
  endtask
  task final_report;
    begin
      if (fail_count == 0 && n_checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  // ============================================================
  // Hang guard, sized well above the expected run of roughly a thousand cycles
  always @(posedge clk) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 12000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, flt} = 10'h0;
    {osc_good, clocks_good, ext_above, outputs_uv, outputs_dis, prim_above} = 6'h0;
    sync_run = 1'b1;
    do_reset;
    tick(20);
    chk(32'({p_en, s_en, b_en, pin_n, irq, state}), 32'h11);
    rchk(`ADDR_CTRL, 32'hff, 32'h82);
    axw(`ADDR_STATE, 32'h0, `RESP_SLVERR);
    for (n = 0; !use_ext && n < 600; n = n + 1) tick(1);
    chk(32'(use_ext), 1);
    n = 0;
    repeat (150) begin
      tick(1);
      n = n + cyc;
    end
    chk(32'(n >= 19 && n <= 21), 1);
    sync_run <= 1'b0;
    for (n = 0; use_ext && n < 800; n = n + 1) tick(1);
    chk(32'(use_ext), 0);
    do_reset;
    osc_good <= 1'b1;
    clocks_good <= 1'b1;
    recover;
    axw(`ADDR_CTRL, 32'({PWD, 4'h5}), `RESP_OKAY);
    axw(`ADDR_MASK, 32'h3f, `RESP_OKAY);
    fire(0);
    model_err;
    chk(32'({p_en, s_en, b_en, pin_n, irq}), 32'h1d);
    mchk;
    rchk(`ADDR_STATUS, 32'h3f, 32'h1);
    axw(`ADDR_STATUS, 32'h1, `RESP_OKAY);
    tick(2);
    chk(32'({pin_n, irq}), 32'h2);
    recover;
    axw(`ADDR_CTRL, 32'({PWD, 4'h4}), `RESP_OKAY);
    fire(0);
    mchk;
    rchk(`ADDR_STATUS, 32'h3f, 32'h1);
    axw(`ADDR_STATUS, 32'h1, `RESP_OKAY);
    axw(`ADDR_MASK, 32'h37, `RESP_OKAY);
    fire(2);
    mchk;
    rchk(`ADDR_STATUS, 32'h3f, 32'h8);
    chk(32'(irq), 0);
    axw(`ADDR_MASK, 32'h3f, `RESP_OKAY);
    tick(2);
    chk(32'(irq), 1);
    axw(`ADDR_STATUS, 32'h8, `RESP_OKAY);
    tick(2);
    chk(32'(irq), 0);
    fire(1);
    model_err;
    chk(32'({p_en, s_en, b_en, pin_n}), 0);
    mchk;
    axw(`ADDR_STATUS, 32'h2, `RESP_OKAY);
    recover;
    fire(1);
    model_err;
    mchk;
    for (i = 0; i < 2; i = i + 1) begin
      do_reset;
      ext_above <= i[0];
      clocks_good <= !i[0];
      outputs_dis <= i[0];
      recover;
      chk(32'(gate_ext), i);
      fire(3 + i);
      chk(32'({p_en, s_en, b_en, state}), 0);
      rchk(`ADDR_STATUS, 32'h30, 32'h10 << i);
    end
    final_report;
  end
endmodule // sw_clk_fault_ctrl_tb
